// ==== hw/rx_pkg.sv ====
// Shared constants and types for the debug UART receiver and baud generator
package rx_pkg;

   // Divisor width allows rates down to master_clock / (16 * 65535)
   localparam int DIV_W           = 16;
   localparam int OVERSAMPLE      = 16;
   localparam int DATA_BITS       = 8;

   // Start bit low must persist for more than this many sample ticks
   localparam int START_MIN_TICKS = 7;
   // Ticks from the detected falling edge to the first data sample
   localparam int FIRST_SAMPLE    = 24;
   // Ticks between two following samples
   localparam int BIT_SAMPLES     = 16;

   localparam int CNT_W           = 5;
   localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_MIN_TICKS);
   localparam logic [CNT_W-1:0] FIRST_WAIT = CNT_W'(FIRST_SAMPLE - START_MIN_TICKS);
   localparam logic [CNT_W-1:0] BIT_WAIT   = CNT_W'(BIT_SAMPLES);

   typedef logic [DIV_W-1:0]     divisor_t;
   typedef logic [DATA_BITS-1:0] char_t;
   typedef logic [2:0]           parity_t;

   // Parity mode field encodings; any code with the top bit set means no parity
   localparam parity_t PAR_EVEN  = 3'h0;
   localparam parity_t PAR_ODD   = 3'h1;
   localparam parity_t PAR_SPACE = 3'h2;
   localparam parity_t PAR_MARK  = 3'h3;
   localparam parity_t PAR_NONE  = 3'h4;

   // Reset values and the last sample sub-count
   localparam divisor_t DIV_RESET  = 16'h0000;
   localparam char_t    CHAR_RESET = 8'h00;
   localparam logic [3:0] SUB_LAST = 4'hf;

   typedef enum logic [2:0] {
      RX_OFF,
      RX_HUNT,
      RX_START,
      RX_DATA,
      RX_PARITY,
      RX_STOP
   } rx_state_t;

endpackage : rx_pkg

// ==== hw/baud_if.sv ====
// Tick carrier between the baud generator and the receiver
`timescale 1ns/100ps
interface baud_if;
   logic sample_tick;   // 16x sampling enable, one cycle
   logic baud_tick;     // One bit period enable, one cycle
   logic active;        // Divisor is non zero

   modport gen (output sample_tick, output baud_tick, output active);
   modport rx  (input  sample_tick, input  baud_tick, input  active);
endinterface : baud_if

// ==== hw/baud_gen.sv ====
// Baud rate generator: 16x sample enable and bit period enable
`timescale 1ns/100ps
module baud_gen (
   input  wire logic             mclk,          // Master clock
   input  wire logic             sys_rst,       // Async reset, high
   input  wire rx_pkg::divisor_t baud_divisor,  // Divisor, 0 stops
   baud_if.gen                   ticks          // Tick outputs
);
   import rx_pkg::*;

   divisor_t   div_cnt_ff;
   logic [3:0] sub_cnt_ff;
   logic       sample_ff;
   logic       baud_ff;

   // Compare with >= so a divisor lowered mid count cannot overrun the wrap
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt_ff <= DIV_RESET;
         sample_ff  <= 1'b0;
      end else if (baud_divisor == DIV_RESET) begin
         div_cnt_ff <= DIV_RESET;
         sample_ff  <= 1'b0;
      end else if (div_cnt_ff >= baud_divisor - 16'h0001) begin
         div_cnt_ff <= DIV_RESET;
         sample_ff  <= 1'b1;
      end else begin
         div_cnt_ff <= div_cnt_ff + 16'h0001;
         sample_ff  <= 1'b0;
      end
   end

   // Bit period enable, sixteen sample ticks, shared with the transmitter
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sub_cnt_ff <= 4'h0;
         baud_ff    <= 1'b0;
      end else if (baud_divisor == DIV_RESET) begin
         sub_cnt_ff <= 4'h0;
         baud_ff    <= 1'b0;
      end else begin
         baud_ff <= sample_ff && (sub_cnt_ff == SUB_LAST);
         if (sample_ff) begin
            sub_cnt_ff <= sub_cnt_ff + 4'h1;
         end
      end
   end

   assign ticks.sample_tick = sample_ff;
   assign ticks.baud_tick   = baud_ff;
   assign ticks.active      = (baud_divisor != DIV_RESET);
endmodule : baud_gen

// ==== hw/debug_uart_receiver_baud.sv ====
// Debug UART receive path with baud generator and debug channel status
`timescale 1ns/100ps
//
// What this block does
// - The baud clock is the master clock divided by sixteen times the divisor and feeds both halves.
// - A divisor of zero stops the baud clock and leaves the receiver inactive; the debug channel status and interrupt keep running.
// - The divisor is sixteen bits wide, from one up to 65535.
// - The receiver is disabled after reset and starts hunting for a start bit when enabled.
// - Disable stops at once while hunting or checking a start bit, otherwise after the stop bit of the current character.
// - Receiver reset aborts any character at once, discards it and leaves the receiver disabled.
// - A low line is a start bit only when it persists for more than seven sample ticks.
// - The first data sample falls 24 ticks after the falling edge and each later one 16 ticks on.
// - The link has no clock pin and every character carries eight data bits and optional parity.
// - Receiver and transmitter share only the baud generator, with no timeout and no time guard.
// - A finished character goes to the holding register and sets ready, which a read clears.
// - A character arriving while ready is still set raises overrun until clear status.
// - Parity is computed per the parity mode and a mismatch sets parity error with ready.
// - Parity error stays set over later characters until clear status.
// - A low stop bit sets framing error with ready and it holds until clear status.
// - The debug channel status lines are shown to software and raise an interrupt.
module debug_uart_receiver_baud (
   input  wire logic             mclk,               // Master clock, 10 MHz
   input  wire logic             sys_rst,            // Async reset, high
   input  wire logic             serial_rx_pin,      // Receive line
   input  wire rx_pkg::divisor_t baud_divisor,       // Baud divisor, 0 stops
   input  wire rx_pkg::parity_t  parity_mode_field,  // Parity mode
   input  wire logic             rx_enable_cmd,      // Enable strobe
   input  wire logic             rx_disable_cmd,     // Disable strobe
   input  wire logic             rx_reset_cmd,       // Receiver reset strobe
   input  wire logic             clear_status_cmd,   // Clear error flags strobe
   input  wire logic             rx_holding_read,    // Holding register read strobe
   input  wire logic             comm_rx_in,         // Debug channel read full
   input  wire logic             comm_tx_in,         // Debug channel write full
   input  wire logic [1:0]       comm_irq_mask,      // Debug channel interrupt enables
   output      rx_pkg::char_t    rx_holding_reg,     // Received character
   output      logic             rx_ready_flag,      // Character waiting
   output      logic             rx_overrun_flag,    // Overrun seen
   output      logic             parity_error_flag,  // Parity error seen
   output      logic             framing_error_flag, // Framing error seen
   output      logic             rx_enabled,         // Receiver enabled
   output      logic             rx_busy,            // Character in progress
   output      logic             baud_tick,          // Bit period enable to transmitter
   output      logic [1:0]       comm_status,        // Debug channel status
   output      logic             comm_irq            // Debug channel interrupt
);
   import rx_pkg::*;

   baud_if ticks ();

   baud_gen u_baud_gen (
      .mclk         (mclk),
      .sys_rst      (sys_rst),
      .baud_divisor (baud_divisor),
      .ticks        (ticks.gen)
   );

   rx_state_t        state_ff;
   logic             en_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [2:0]       bitn_ff;
   char_t            shift_ff;
   logic             par_bit_ff;
   char_t            hold_ff;
   logic             ready_ff;
   logic             ovr_ff;
   logic             parity_error_flag_ff;
   logic             frame_ff;
   logic [1:0]       comm_ff;
   logic             irq_ff;

   logic             tick;
   logic             sample_now;
   logic             parity_on;
   logic             expect_par;
   logic             char_done;
   logic             stop_bit;
   logic             par_bad;
   logic             hold_load;
   logic             stop_req;
   logic             qual_done;
   logic             last_bit;

   assign tick      = ticks.sample_tick && ticks.active;
   assign parity_on = !parity_mode_field[2];
   // Sample point of the current bit: wait counter expiring on a tick
   assign sample_now = tick && (cnt_ff == CNT_W'(1));

   always_comb begin
      expect_par = 1'b0;
      case (parity_mode_field)
         PAR_EVEN:  expect_par = ^shift_ff;
         PAR_ODD:   expect_par = ~^shift_ff;
         PAR_SPACE: expect_par = 1'b0;
         PAR_MARK:  expect_par = 1'b1;
         default:   expect_par = 1'b0;
      endcase
   end

   assign char_done = (state_ff == RX_STOP) && sample_now;
   assign stop_bit  = serial_rx_pin;
   assign par_bad   = parity_on && (par_bit_ff != expect_par);

   // A receiver reset in the completing cycle drops the character
   assign hold_load = char_done && !rx_reset_cmd;
   // Disable before a start is qualified stops at once
   assign stop_req  = rx_disable_cmd || !en_ff;
   assign qual_done = (cnt_ff + CNT_W'(1) == START_LAST);
   assign last_bit  = (bitn_ff == 3'(DATA_BITS - 1));

   // Enable bit; a disable in the same cycle as an enable wins
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         en_ff <= 1'b0;
      end else if (rx_reset_cmd || rx_disable_cmd) begin
         en_ff <= 1'b0;
      end else if (rx_enable_cmd) begin
         en_ff <= 1'b1;
      end
   end

   // Start check: the first low tick enters the start state and seven more low
   // ticks confirm it; one high tick in between is taken as a glitch. The wait
   // counter is then preloaded so data bit 0 is taken 24 ticks after the first
   // low tick. The line is used as is, so it must already be in this domain.
   // Receive sequencer, bit timing advanced only by sample ticks
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= RX_OFF;
         cnt_ff   <= '0;
         bitn_ff  <= 3'h0;
      end else if (rx_reset_cmd) begin
         state_ff <= RX_OFF;
         cnt_ff   <= '0;
         bitn_ff  <= 3'h0;
      end else begin
         case (state_ff)
            RX_OFF: begin
               if (rx_enable_cmd && !rx_disable_cmd) begin
                  state_ff <= RX_HUNT;
               end
            end
            RX_HUNT: begin
               if (stop_req) begin
                  state_ff <= RX_OFF;
               end else if (tick && !serial_rx_pin) begin
                  state_ff <= RX_START;
                  cnt_ff   <= '0;
               end
            end
            RX_START: begin
               // Still waiting for a valid start: a disable stops at once
               if (stop_req) begin
                  state_ff <= RX_OFF;
               end else if (tick) begin
                  if (serial_rx_pin) begin
                     state_ff <= RX_HUNT;
                  end else if (qual_done) begin
                     state_ff <= RX_DATA;
                     cnt_ff   <= FIRST_WAIT;
                     bitn_ff  <= 3'h0;
                  end else begin
                     cnt_ff <= cnt_ff + CNT_W'(1);
                  end
               end
            end
            RX_DATA: begin
               if (sample_now) begin
                  cnt_ff  <= BIT_WAIT;
                  bitn_ff <= bitn_ff + 3'h1;
                  if (last_bit) begin
                     state_ff <= parity_on ? RX_PARITY : RX_STOP;
                  end
               end else if (tick) begin
                  cnt_ff <= cnt_ff - CNT_W'(1);
               end
            end
            RX_PARITY: begin
               if (sample_now) begin
                  cnt_ff   <= BIT_WAIT;
                  state_ff <= RX_STOP;
               end else if (tick) begin
                  cnt_ff <= cnt_ff - CNT_W'(1);
               end
            end
            RX_STOP: begin
               if (sample_now) begin
                  // A pending disable takes effect once the stop bit is in
                  state_ff <= en_ff ? RX_HUNT : RX_OFF;
                  cnt_ff   <= '0;
               end else if (tick) begin
                  cnt_ff <= cnt_ff - CNT_W'(1);
               end
            end
            default: begin
               state_ff <= RX_OFF;
            end
         endcase
      end
   end

   // Data capture, least significant bit first
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_ff <= CHAR_RESET;
      end else if (sample_now && state_ff == RX_DATA) begin
         shift_ff <= {serial_rx_pin, shift_ff[DATA_BITS-1:1]};
      end
   end

   // Parity bit capture, left stale when parity is off
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         par_bit_ff <= 1'b0;
      end else if (sample_now && state_ff == RX_PARITY) begin
         par_bit_ff <= serial_rx_pin;
      end
   end

   // Holding register; receiver reset drops only the partial character
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_ff <= CHAR_RESET;
      end else if (hold_load) begin
         hold_ff <= shift_ff;
      end
   end

   // Ready: a new character wins over a read in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ready_ff <= 1'b0;
      end else if (hold_load) begin
         ready_ff <= 1'b1;
      end else if (rx_holding_read) begin
         ready_ff <= 1'b0;
      end
   end

   // Overrun: setting wins over clear status, a read in time avoids it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ovr_ff <= 1'b0;
      end else if (hold_load && ready_ff && !rx_holding_read) begin
         ovr_ff <= 1'b1;
      end else if (clear_status_cmd) begin
         ovr_ff <= 1'b0;
      end
   end

   // Parity error, only ever set while parity is enabled
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         parity_error_flag_ff <= 1'b0;
      end else if (hold_load && par_bad) begin
         parity_error_flag_ff <= 1'b1;
      end else if (clear_status_cmd) begin
         parity_error_flag_ff <= 1'b0;
      end
   end

   // Framing error, checked whatever the parity mode
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_ff <= 1'b0;
      end else if (hold_load && !stop_bit) begin
         frame_ff <= 1'b1;
      end else if (clear_status_cmd) begin
         frame_ff <= 1'b0;
      end
   end

   // Debug channel status, one cycle behind the lines
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         comm_ff <= 2'h0;
      end else begin
         comm_ff <= {comm_tx_in, comm_rx_in};
      end
   end

   // Channel interrupt, masked per line and aligned with the status
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |({comm_tx_in, comm_rx_in} & comm_irq_mask);
      end
   end

   assign rx_holding_reg     = hold_ff;
   assign rx_ready_flag      = ready_ff;
   assign rx_overrun_flag    = ovr_ff;
   assign parity_error_flag  = parity_error_flag_ff;
   assign framing_error_flag = frame_ff;
   assign rx_enabled         = en_ff;
   assign rx_busy            = (state_ff == RX_DATA) || (state_ff == RX_PARITY) ||
                               (state_ff == RX_STOP);
   // Transmit side shares only this enable, no timeout or guard logic here
   assign baud_tick          = ticks.baud_tick;
   assign comm_status        = comm_ff;
   assign comm_irq           = irq_ff;
endmodule : debug_uart_receiver_baud

// ==== testbench/rx_asserts.sv ====
// Port-level assertions for the debug UART receiver
`timescale 1ns/100ps
module rx_asserts (
   input wire logic             mclk,               // Clock
   input wire logic             sys_rst,            // Reset
   input wire rx_pkg::divisor_t baud_divisor,       // Divisor
   input wire logic             rx_enable_cmd,      // Enable
   input wire logic             rx_disable_cmd,     // Disable
   input wire logic             rx_reset_cmd,       // Abort
   input wire logic             clear_status_cmd,   // Clear
   input wire logic             rx_holding_read,    // Read
   input wire logic             comm_rx_in,         // Chan rx
   input wire logic             comm_tx_in,         // Chan tx
   input wire logic [1:0]       comm_irq_mask,      // Chan mask
   input wire logic             rx_ready_flag,      // Ready
   input wire logic             rx_overrun_flag,    // Overrun
   input wire logic             parity_error_flag,  // Parity
   input wire logic             framing_error_flag, // Framing
   input wire logic             rx_enabled,         // Enabled
   input wire logic             rx_busy,            // Busy
   input wire logic             baud_tick,          // Bit tick
   input wire logic [1:0]       comm_status,        // Chan status
   input wire logic             comm_irq            // Chan irq
);
   import rx_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [20:0] gap_ff;
   logic        ok_ff;
   divisor_t    div_ff;
   // Spacing only trusted from the second tick after a divisor change
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_ff <= 21'h000000;
         ok_ff  <= 1'b0;
         div_ff <= 16'h0000;
      end else begin
         gap_ff <= baud_tick ? 21'h000001 : gap_ff + 21'h000001;
         div_ff <= baud_divisor;
         if (baud_divisor != div_ff) ok_ff <= 1'b0;
         else if (baud_tick) ok_ff <= 1'b1;
      end
   end
   a_baud_period: assert property (baud_tick && ok_ff && baud_divisor == div_ff
      |-> gap_ff == {1'b0, baud_divisor, 4'h0}) else $error("baud tick spacing wrong");
   a_div_zero_still: assert property (baud_divisor == 0 && $past(baud_divisor) == 0
      && $past(baud_divisor, 2) == 0 |-> !baud_tick && !$rose(rx_ready_flag))
      else $error("activity with zero divisor");
   a_enable_takes: assert property (rx_enable_cmd && !rx_disable_cmd && !rx_reset_cmd
      |=> rx_enabled) else $error("enable not taken");
   a_idle_disable: assert property (rx_disable_cmd && !rx_busy |=> !rx_enabled && !rx_busy)
      else $error("idle disable not immediate");
   a_reset_aborts: assert property (rx_reset_cmd |=> !rx_enabled && !rx_busy)
      else $error("receiver reset did not abort");
   a_read_clears: assert property (rx_holding_read && !rx_busy |=> !rx_ready_flag)
      else $error("read did not clear ready");
   a_overrun_cause: assert property ($rose(rx_overrun_flag) |-> $past(rx_ready_flag))
      else $error("overrun without pending char");
   a_overrun_holds: assert property (rx_overrun_flag && !clear_status_cmd
      |=> rx_overrun_flag) else $error("overrun dropped");
   a_parity_ready: assert property ($rose(parity_error_flag)
      |-> rx_ready_flag && $past(rx_busy)) else $error("parity error apart from ready");
   a_parity_holds: assert property (parity_error_flag && !clear_status_cmd
      |=> parity_error_flag) else $error("parity error dropped");
   a_frame_ready: assert property ($rose(framing_error_flag)
      |-> rx_ready_flag && $past(rx_busy)) else $error("framing error apart from ready");
   a_frame_holds: assert property (framing_error_flag && !clear_status_cmd
      |=> framing_error_flag) else $error("framing error dropped");
   a_status_clears: assert property (clear_status_cmd && !rx_busy
      |=> !rx_overrun_flag && !parity_error_flag && !framing_error_flag)
      else $error("clear status ignored");
   a_comm_mirror: assert property (!$past(sys_rst) |-> comm_status ==
      $past({comm_tx_in, comm_rx_in}) && comm_irq ==
      $past(|(comm_irq_mask & {comm_tx_in, comm_rx_in}))) else $error("channel status wrong");
endmodule : rx_asserts
bind debug_uart_receiver_baud rx_asserts rx_asserts_inst (.mclk, .sys_rst, .baud_divisor,
   .rx_enable_cmd, .rx_disable_cmd, .rx_reset_cmd, .clear_status_cmd, .rx_holding_read,
   .comm_rx_in, .comm_tx_in, .comm_irq_mask, .rx_ready_flag, .rx_overrun_flag,
   .parity_error_flag, .framing_error_flag, .rx_enabled, .rx_busy, .baud_tick,
   .comm_status, .comm_irq);

// ==== testbench/serial_peer.sv ====
// Serial terminal model sending framed characters, LSB first
`timescale 1ns/100ps
module serial_peer (
   input  wire logic        mclk,       // Clock
   input  wire logic        go,         // Start a frame
   input  wire logic [10:0] frame,      // Bits, start bit at 0
   input  wire logic [3:0]  nbits,      // Bits to send
   input  wire integer      bit_cycles, // Clocks per bit
   output logic             line,       // Serial line, idle high
   output logic             busy        // Frame in progress
);
   initial begin
      line = 1'b1;
      busy = 1'b0;
   end
   // Last bit cut to 3/4 so a low stop bit cannot look like a new start
   always @(posedge mclk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         for (int i = 0; i < nbits; i++) begin
            line <= frame[i];
            repeat (i == nbits - 1 ? bit_cycles * 3 / 4 : bit_cycles) @(posedge mclk);
         end
         line <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule : serial_peer

// ==== testbench/debug_uart_receiver_baud_bench.sv ====
// Self-checking bench for the debug UART receiver
`timescale 1ns/100ps
module debug_uart_receiver_baud_bench;
   import rx_pkg::*;
   logic        mclk, sys_rst, go, busy, line, comm_rx_in, comm_tx_in;
   logic        ready, ovr, perr, ferr, en, rbusy, btick, irq;
   logic [4:0]  cmd_v;
   logic [1:0]  mask, status;
   logic [10:0] frame;
   logic [3:0]  nbits;
   divisor_t    div;
   parity_t     pmode;
   char_t       hold;
   int          bitc, bp, fail_count, n_checks, ticks, t0;
   debug_uart_receiver_baud debug_uart_receiver_baud_inst (.mclk(mclk), .sys_rst(sys_rst),
      .serial_rx_pin(line), .baud_divisor(div), .parity_mode_field(pmode),
      .rx_enable_cmd(cmd_v[0]), .rx_disable_cmd(cmd_v[1]), .rx_reset_cmd(cmd_v[2]),
      .clear_status_cmd(cmd_v[3]), .rx_holding_read(cmd_v[4]), .comm_rx_in(comm_rx_in),
      .comm_tx_in(comm_tx_in), .comm_irq_mask(mask), .rx_holding_reg(hold),
      .rx_ready_flag(ready), .rx_overrun_flag(ovr), .parity_error_flag(perr),
      .framing_error_flag(ferr), .rx_enabled(en), .rx_busy(rbusy), .baud_tick(btick),
      .comm_status(status), .comm_irq(irq));
   serial_peer serial_peer_inst (.mclk(mclk), .go(go), .frame(frame), .nbits(nbits),
      .bit_cycles(bitc), .line(line), .busy(busy));
   always #50 mclk = ~mclk;
   // Counted on the falling edge so the tests' reads never race it
   always @(negedge mclk) if (btick === 1'b1) ticks++;
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %0s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Bits: enable, disable, reset, clear status, read
   task automatic cmd(input logic [4:0] c);
      @(posedge mclk) cmd_v <= c;
      @(posedge mclk) cmd_v <= 5'h00;
   endtask : cmd
   task automatic send(input logic [10:0] f, input logic [3:0] n, input int bc);
      @(posedge mclk) begin
         frame <= f;
         nbits <= n;
         bitc  <= bc;
         go    <= 1'b1;
      end
      @(posedge mclk) go <= 1'b0;
      tick(1);
      while (busy) tick(1);
      tick(3);
   endtask : send
   task automatic rx(input char_t d, input parity_t m, input logic bad, input logic stp);
      logic p;
      p = (m == PAR_EVEN) ? ^d : (m == PAR_ODD) ? ~^d : (m == PAR_MARK);
      @(posedge mclk) pmode <= m;
      if (m[2]) send({1'b1, stp, d, 1'b0}, 4'ha, bp);
      else send({stp, p ^ bad, d, 1'b0}, 4'hb, bp);
   endtask : rx
   task automatic done(input string name);
      $display("test %0s done", name);
   endtask : done
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   initial begin
      tick(60000);
      fail_count++;
      summarize();
   end
   initial begin
      mclk = 0; sys_rst = 1; go = 0; div = 16'h0000; pmode = PAR_NONE; cmd_v = 5'h00;
      comm_rx_in = 0; comm_tx_in = 0; mask = 2'h0; frame = 11'h7ff; nbits = 4'h0;
      bitc = 16; bp = 16; fail_count = 0; n_checks = 0; ticks = 0; t0 = 0;
      tick(6);
      sys_rst <= 1'b0;
      div <= 16'h0001;
      tick(2);
      chk("enabled", en, 16'h0000);
      rx(8'h3c, PAR_NONE, 0, 1);
      chk("ready", ready, 16'h0000);
      cmd(5'h01);
      tick(1);
      chk("enabled", en, 16'h0001);
      rx(8'ha5, PAR_NONE, 0, 1);
      chk("holding", hold, 16'h00a5);
      chk("ready", ready, 16'h0001);
      cmd(5'h10);
      tick(1);
      chk("ready", ready, 16'h0000);
      done("basic");
      for (int m = 0; m < 4; m++) begin
         rx(8'h5a + 8'(m), parity_t'(m), 0, 1);
         chk("holding", hold, 16'(8'h5a + 8'(m)));
         chk("parity", perr, 16'h0000);
         cmd(5'h10);
      end
      rx(8'h96, PAR_ODD, 1, 1);
      chk("parity", perr, 16'h0001);
      chk("ready", ready, 16'h0001);
      cmd(5'h10);
      rx(8'h01, PAR_EVEN, 0, 1);
      chk("parity", perr, 16'h0001);
      cmd(5'h18);
      tick(1);
      chk("parity", perr, 16'h0000);
      done("parity");
      rx(8'h11, PAR_NONE, 0, 1);
      rx(8'h22, PAR_NONE, 0, 1);
      chk("holding", hold, 16'h0022);
      chk("overrun", ovr, 16'h0001);
      cmd(5'h10);
      rx(8'h33, PAR_NONE, 0, 1);
      chk("overrun", ovr, 16'h0001);
      cmd(5'h18);
      tick(1);
      chk("overrun", ovr, 16'h0000);
      rx(8'h44, PAR_NONE, 0, 0);
      chk("framing", ferr, 16'h0001);
      chk("ready", ready, 16'h0001);
      cmd(5'h18);
      tick(1);
      chk("framing", ferr, 16'h0000);
      done("overrun framing");
      send(11'h002, 4'h2, 7);
      chk("ready", ready, 16'h0000);
      send(11'h002, 4'h2, 8);
      tick(170);
      chk("holding", hold, 16'h00ff);
      chk("ready", ready, 16'h0001);
      cmd(5'h10);
      done("start");
      fork
         rx(8'h69, PAR_NONE, 0, 1);
         begin tick(60); cmd(5'h02); end
      join
      chk("holding", hold, 16'h0069);
      chk("enabled", en, 16'h0000);
      cmd(5'h10);
      rx(8'h77, PAR_NONE, 0, 1);
      chk("ready", ready, 16'h0000);
      cmd(5'h01);
      cmd(5'h02);
      tick(1);
      chk("enabled", en, 16'h0000);
      cmd(5'h01);
      fork
         rx(8'h5c, PAR_NONE, 0, 1);
         begin tick(60); cmd(5'h04); end
      join
      chk("ready", ready, 16'h0000);
      chk("enabled", en, 16'h0000);
      cmd(5'h01);
      rx(8'hc3, PAR_NONE, 0, 1);
      chk("holding", hold, 16'h00c3);
      cmd(5'h10);
      done("disable abort");
      @(posedge mclk) div <= 16'h0003;
      bp = 48;
      rx(8'h3a, PAR_EVEN, 0, 1);
      chk("holding", hold, 16'h003a);
      cmd(5'h10);
      t0 = ticks;
      tick(480);
      chk("baud ticks", 16'(ticks - t0), 16'h000a);
      @(posedge mclk) div <= 16'h0000;
      tick(3);
      t0 = ticks;
      rx(8'h12, PAR_NONE, 0, 1);
      chk("ready", ready, 16'h0000);
      chk("baud ticks", 16'(ticks - t0), 16'h0000);
      done("divisor");
      for (int j = 0; j < 16; j++) begin
         @(posedge mclk) {mask, comm_tx_in, comm_rx_in} <= 4'(j);
         tick(2);
         chk("status", status, 16'(j[1:0]));
         chk("irq", irq, 16'(|(j[3:2] & j[1:0])));
      end
      done("channel");
      summarize();
   end
endmodule : debug_uart_receiver_baud_bench
